/* File: dr_pkg.sv */
// Purpose: constants and types for the disturbance recorder control block
// Assumes: 125 MHz clock; times held in milliseconds; sizes in bytes
// Notes on behaviour
// RULE1 - binary channels sampled every 5 ms
// RULE2 - manual or enabled input starts recording
// RULE3 - every binary channel selectable as trigger
// RULE4 - never more than 100 stored recordings
// RULE5 - enable setting: zero on, one off
// RULE6 - state code 0 to 5 reported
// RULE7 - index n deletes the nth recording
// RULE8 - manual trigger starts, then returns idle
// RULE9 - clear all deletes every recording
// RULE10 - clear newest deletes latest recording only
// RULE11 - clear oldest deletes earliest recording only
// RULE12 - report recordings that fit, up to 100
// RULE13 - report longest recording, 1 ms steps
// RULE14 - report largest pre-trigger time, 1 ms steps
// RULE15 - stored count follows each store, deletion
// RULE16 - size from channels, rate, recording time
// RULE17 - protection frequency falls back to nominal
// RULE18 - display frequency zero when unmeasurable
// RULE19 - phase flag zero ABC, one ACB
// RULE20 - constant false and true channels
// RULE21 - alarm channel while time sync lost
// RULE22 - fault channel while internal fault present
// RULE23 - full: fifo overwrites, keep mode refuses
// RULE24 - pre-trigger span in 0.1 s, default 0.2
// RULE25 - disabled or bad config ignores triggers
// RULE26 - no overlapping recording while capturing
package dr_pkg;
    localparam int CLOCK_MHZ        = 125;
    localparam int SAMPLE_PERIOD_US = 5000;
    localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLOCK_MHZ;
    localparam int MS_US            = 1000;
    localparam int MS_CYCLES        = MS_US * CLOCK_MHZ;
    localparam int SAMPLES_PER_S    = 1000000 / SAMPLE_PERIOD_US;
    localparam int MAX_RECORDS      = 100;
    localparam int MAX_LEN_MS       = 1800000;
    localparam int PRE_STEP_MS      = 100;
    localparam logic [7:0] PRE_STEPS_RESET = 8'h02;
    localparam int STORE_CYCLES     = 4;
    localparam int SAMPLE_BYTES     = 2;
    localparam logic REC_ENABLED    = 1'b0;
    localparam logic MODE_FIFO      = 1'b0;
    localparam logic PHASE_ABC      = 1'b0;
    // fixed internal channel positions ahead of the external inputs
    localparam int CH_FALSE = 0;
    localparam int CH_TRUE  = 1;
    localparam int CH_NTP   = 2;
    localparam int CH_FAULT = 3;
    localparam int CH_PHASE = 4;
    localparam int CH_EXT   = 5;

    typedef enum logic [2:0] {
        ST_READY = 3'h0,
        ST_TRIG  = 3'h1,
        ST_REC   = 3'h2,
        ST_STORE = 3'h3,
        ST_FULL  = 3'h4,
        ST_WRONG = 3'h5
    } rec_state_e;

    typedef struct packed {
        logic        all;
        logic        newest;
        logic        oldest;
        logic        by_index;
        logic [31:0] index;
    } clear_cmd_s;

    typedef struct packed {
        logic [6:0]  max_count;
        logic [20:0] max_len_ms;
        logic [20:0] max_pre_ms;
        logic [6:0]  stored;
    } capacity_s;
endpackage

/* File: disturbance_recorder_control.sv */
// Purpose: trigger, state and capacity logic of a disturbance recorder
// Assumes: settings arrive as same-clock ports; binary_in comes from pins
// Notes: commands are one-cycle pulses; capture itself is outside this block
`timescale 1ns/100ps
`default_nettype none
module disturbance_recorder_control
    import dr_pkg::*;
#(
    parameter int NUM_EXT       = 16,
    parameter int SAMPLE_DIV    = SAMPLE_CYCLES,
    parameter int MS_DIV        = MS_CYCLES,
    parameter int MEM_BYTES     = 65536000,
    parameter logic [15:0] NOM_CHZ = 16'h1388
) (
    input  wire logic                      clock,
    input  wire logic                      nrst,
    input  wire logic [NUM_EXT-1:0]        binary_in,
    input  wire logic [NUM_EXT+CH_EXT-1:0] trigger_select,
    input  wire logic                      recorder_disable,
    input  wire logic                      recording_mode,
    input  wire logic [20:0]               record_length_ms,
    input  wire logic [7:0]                pretrigger_steps,
    input  wire logic [4:0]                analog_channels,
    input  wire logic [1:0]                analog_rate_sel,
    input  wire logic                      manual_trigger,
    input  wire clear_cmd_s                clear_cmd,
    input  wire logic [15:0]               freq_measured,
    input  wire logic                      freq_valid,
    input  wire logic                      ntp_sync_lost,
    input  wire logic                      internal_fault,
    input  wire logic                      phase_reversed,
    output logic [2:0]                     recorder_state,
    output logic                           manual_setting,
    output capacity_s                      capacity,
    output logic [NUM_EXT+CH_EXT-1:0]      sampled_channels,
    output logic                           sample_tick,
    output logic                           record_start,
    output logic                           record_stored,
    output logic [15:0]                    freq_protection,
    output logic [15:0]                    freq_display,
    output logic                           phase_order_flag
);
    localparam int NCH = NUM_EXT + CH_EXT;

    // elaboration-time refusal of values the counters cannot serve
    // the tick assertion needs two quiet cycles between ticks
    if (NUM_EXT < 1 || SAMPLE_DIV < 3 || MS_DIV < 2 || MEM_BYTES < 1) begin : g_bad_param
        $error("disturbance_recorder_control: bad parameter value");
    end

    // two-stage synchroniser; stage one feeds only stage two
    logic [NUM_EXT-1:0] sync_a;
    logic [NUM_EXT-1:0] sync_b;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= binary_in;
            sync_b <= sync_a;
        end
    end

    // channel vector with internal signals in front
    logic [NCH-1:0] live_ch;
    always_comb begin
        live_ch           = '0;
        live_ch[CH_FALSE] = 1'b0;           // RULE20
        live_ch[CH_TRUE]  = 1'b1;           // RULE20
        live_ch[CH_NTP]   = ntp_sync_lost;  // RULE21
        live_ch[CH_FAULT] = internal_fault; // RULE22
        live_ch[CH_PHASE] = phase_reversed;
        live_ch[NCH-1:CH_EXT] = sync_b;
    end

    // capacity figures; size grows with channels, rate and length
    logic [31:0] spc;
    logic [47:0] bytes_per_s;
    logic [63:0] len_bytes;
    logic [63:0] fit_count;
    logic [63:0] fit_ms;
    logic [20:0] pre_ms;
    logic [6:0]  cap_count;
    logic [20:0] cap_len;
    logic [20:0] cap_pre;
    always_comb begin
        spc         = 32'h0000_0040 >> analog_rate_sel;
        bytes_per_s = 48'(analog_channels) * 48'(spc) * 48'(NOM_CHZ / 16'h0064)
                    * 48'(SAMPLE_BYTES)
                    + 48'((NCH + 7) / 8) * 48'(SAMPLES_PER_S); // RULE16
        len_bytes   = 64'(bytes_per_s) * 64'(record_length_ms) / 64'(1000);
        fit_count   = (len_bytes == 64'h0) ? 64'(MAX_RECORDS)
                    : 64'(MEM_BYTES) / len_bytes;
        fit_ms      = 64'(MEM_BYTES) * 64'(1000) / 64'(bytes_per_s);
        pre_ms      = 21'(32'(pretrigger_steps) * PRE_STEP_MS); // RULE24
        cap_count   = (fit_count > 64'(MAX_RECORDS)) ? 7'(MAX_RECORDS)
                    : 7'(fit_count); // RULE12
        cap_len     = (fit_ms > 64'(MAX_LEN_MS)) ? 21'(MAX_LEN_MS) : 21'(fit_ms); // RULE13
        cap_pre     = (cap_len < record_length_ms) ? cap_len : record_length_ms; // RULE14
    end

    // control state
    rec_state_e     state;
    rec_state_e     next_state;
    logic [31:0]    sdiv;
    logic [31:0]    next_sdiv;
    logic [31:0]    mdiv;
    logic [31:0]    next_mdiv;
    logic [20:0]    post_left;
    logic [20:0]    next_post_left;
    logic [2:0]     store_left;
    logic [2:0]     next_store_left;
    logic [6:0]     stored;
    logic [6:0]     next_stored;
    logic [NCH-1:0] prev_ch;
    logic [NCH-1:0] next_prev_ch;
    logic [NCH-1:0] next_sampled;
    logic           auto_hit;
    logic           next_auto_hit;
    logic           next_manual;
    logic           next_tick;
    logic           next_start;
    logic           next_stored_p;
    logic           bad_cfg;
    logic           fire;
    logic           ms_tick;
    logic           room;
    logic           dec;
    rec_state_e     idle_state;

    always_comb begin
        next_state      = state;
        next_post_left  = post_left;
        next_store_left = store_left;
        next_prev_ch    = prev_ch;
        next_sampled    = sampled_channels;
        next_auto_hit   = 1'b0;
        next_start      = 1'b0;
        next_stored_p   = 1'b0;
        // fixed 5 ms sampling whatever the analog rate
        next_tick = (sdiv == 32'(SAMPLE_DIV - 1)); // RULE1
        next_sdiv = next_tick ? 32'h0000_0000 : sdiv + 32'h0000_0001;
        ms_tick   = (mdiv == 32'(MS_DIV - 1));
        next_mdiv = ms_tick ? 32'h0000_0000 : mdiv + 32'h0000_0001;
        if (sample_tick) begin
            next_sampled  = live_ch;
            next_prev_ch  = live_ch;
            // rising edge of any selected channel arms a trigger
            next_auto_hit = |(live_ch & ~prev_ch & trigger_select); // RULE2 RULE3
        end
        // setting falls back to idle one cycle after the write
        next_manual = manual_trigger; // RULE8
        bad_cfg     = (cap_count == 7'h00) || (pre_ms >= record_length_ms);
        fire        = (recorder_disable == REC_ENABLED) && !bad_cfg
                    && (manual_setting || auto_hit); // RULE25 RULE5
        room        = (stored < cap_count) || (recording_mode == MODE_FIFO); // RULE23
        idle_state  = bad_cfg ? ST_WRONG
                    : (stored >= cap_count) ? ST_FULL : ST_READY; // RULE6
        unique case (state)
            ST_READY, ST_FULL, ST_WRONG: begin
                // triggers during capture never reach here
                if (fire && room) begin // RULE26
                    next_state     = ST_TRIG;
                    next_start     = 1'b1;
                    next_post_left = record_length_ms - pre_ms;
                end else begin
                    next_state = idle_state;
                end
            end
            ST_TRIG: begin
                next_state = ST_REC;
            end
            ST_REC: begin
                if (ms_tick) begin
                    next_post_left = post_left - 21'h00_0001;
                end
                if (ms_tick && post_left <= 21'h00_0001) begin
                    next_state      = ST_STORE;
                    next_store_left = 3'(STORE_CYCLES - 1);
                end
            end
            ST_STORE: begin
                next_store_left = store_left - 3'h1;
                if (store_left == 3'h0) begin
                    next_state    = idle_state;
                    next_stored_p = 1'b1;
                end
            end
            default: begin
                next_state = ST_WRONG;
            end
        endcase
        // deletions; a store in the same cycle still counts
        dec = (clear_cmd.newest || clear_cmd.oldest) && stored != 7'h00; // RULE10 RULE11
        if (clear_cmd.by_index && clear_cmd.index != 32'h0000_0000
            && clear_cmd.index <= 32'(stored)) begin
            dec = 1'b1; // RULE7
        end
        next_stored = stored - 7'(dec);
        if (clear_cmd.all) begin
            next_stored = 7'h00; // RULE9
        end
        if (record_stored) begin
            // when full in fifo mode the oldest is overwritten
            // judged after this cycle's deletions, so a clear at the limit frees a slot
            if (next_stored < 7'(MAX_RECORDS) && next_stored < cap_count) begin
                next_stored = next_stored + 7'h01; // RULE15 RULE4
            end
        end
    end

    // registers only; outputs come straight from flops
    // capacity takes next_stored so the count shows on the same edge as stored
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state            <= ST_READY;
            sdiv             <= '0;
            mdiv             <= '0;
            post_left        <= '0;
            store_left       <= '0;
            stored           <= '0;
            prev_ch          <= '0;
            sampled_channels <= '0;
            auto_hit         <= 1'b0;
            manual_setting   <= 1'b0;
            sample_tick      <= 1'b0;
            record_start     <= 1'b0;
            record_stored    <= 1'b0;
            capacity         <= '0;
            freq_protection  <= '0;
            freq_display     <= '0;
            phase_order_flag <= PHASE_ABC;
        end else begin
            state            <= next_state;
            sdiv             <= next_sdiv;
            mdiv             <= next_mdiv;
            post_left        <= next_post_left;
            store_left       <= next_store_left;
            stored           <= next_stored;
            prev_ch          <= next_prev_ch;
            sampled_channels <= next_sampled;
            auto_hit         <= next_auto_hit;
            manual_setting   <= next_manual;
            sample_tick      <= next_tick;
            record_start     <= next_start;
            record_stored    <= next_stored_p;
            capacity         <= '{cap_count, cap_len, cap_pre, next_stored};
            freq_protection  <= freq_valid ? freq_measured : NOM_CHZ; // RULE17
            freq_display     <= freq_valid ? freq_measured : 16'h0000; // RULE18
            phase_order_flag <= phase_reversed; // RULE19
        end
    end

    assign recorder_state = state;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_tick_period: assert property (sample_tick |=> !sample_tick [*2]) // RULE1
        else $error("sample tick repeated too soon");
    a_start_cause: assert property (record_start |-> $past(fire)) // RULE2
        else $error("recording started without trigger");
    a_no_overlap: assert property (record_start // RULE26
        |-> !($past(state) inside {ST_TRIG, ST_REC, ST_STORE}))
        else $error("overlapping recording started");
    a_disabled_quiet: assert property ($past(recorder_disable) |-> !record_start) // RULE25
        else $error("trigger taken while disabled");
    a_count_limit: assert property (stored <= 7'(MAX_RECORDS)) // RULE4
        else $error("stored count over limit");
    a_clear_all: assert property (clear_cmd.all && !record_stored |=> stored == 7'h00) // RULE9
        else $error("clear all left recordings");
    a_manual_idle: assert property (manual_setting && !manual_trigger |=> !manual_setting) // RULE8
        else $error("manual setting stuck");
    a_trig_to_rec: assert property (state == ST_TRIG |=> state == ST_REC) // RULE6
        else $error("triggered state did not move on");
    a_freq_disp: assert property (!$past(freq_valid) |-> freq_display == 16'h0000) // RULE18
        else $error("display frequency not zero");
    a_freq_prot: assert property (!$past(freq_valid) |-> freq_protection == NOM_CHZ) // RULE17
        else $error("protection frequency not nominal");
    a_keep_refuse: assert property (recording_mode != MODE_FIFO && stored >= cap_count // RULE23
        && state == ST_FULL |=> !record_start)
        else $error("keep mode accepted when full");
    a_store_len: assert property (state == ST_STORE && store_left == 3'h0 // RULE15
        |=> record_stored)
        else $error("store did not complete");

    // the count moves by exactly what each command and store allows; bad config forces ST_WRONG
    a_newest_step: assert property (clear_cmd.newest && !clear_cmd.all // RULE10
        && !record_stored && stored != 7'h00 |=> stored == $past(stored) - 7'h01)
        else $error("clear newest did not remove one");
    a_index_zero: assert property (clear_cmd.by_index && !clear_cmd.all // RULE7
        && clear_cmd.index == 32'h0000_0000 && !clear_cmd.newest && !clear_cmd.oldest
        && !record_stored |=> $stable(stored))
        else $error("index zero removed a recording");
    a_fifo_hold: assert property (record_stored && recording_mode == MODE_FIFO // RULE23
        && stored >= cap_count && !dec && !clear_cmd.all |=> $stable(stored))
        else $error("fifo overwrite changed the count");
    a_wrong_cfg: assert property (bad_cfg && (state == ST_READY || state == ST_FULL // RULE6
        || state == ST_WRONG) |=> state == ST_WRONG)
        else $error("bad configuration not reported");

    // main scenarios: manual, automatic, store, full and overwrite when full
    c_manual_rec: cover property (manual_setting ##1 record_start);
    c_auto_rec: cover property (auto_hit ##1 record_start);
    c_stored: cover property (record_stored ##1 stored != 7'h00);
    c_full: cover property (state == ST_FULL);
    c_fifo_full: cover property (state == ST_FULL ##1 record_start);
endmodule
`default_nettype wire

/* File: tb_disturbance_recorder_control.sv */
// Purpose: self-checking bench for the disturbance recorder control block
// Assumes: short dividers (sample 10, ms 4 cycles); 3 ms records, no pre-trigger
// Notes: a tiny memory holds three records, so full, keep and fifo modes are reached
`timescale 1ns/100ps
`default_nettype none
module tb_disturbance_recorder_control;
    import dr_pkg::*;
    localparam int NE   = 4;
    localparam int SDIV = 10;
    localparam int NCH  = NE + CH_EXT;
    logic            clock;
    logic            nrst;
    logic [NE-1:0]   binary_in;
    logic [NCH-1:0]  trigger_select;
    logic            recorder_disable;
    logic            recording_mode;
    logic [7:0]      pretrigger_steps;
    logic            manual_trigger;
    clear_cmd_s      clear_cmd;
    logic [15:0]     freq_measured;
    logic            freq_valid;
    logic            ntp_sync_lost;
    logic            internal_fault;
    logic            phase_reversed;
    logic [2:0]      recorder_state;
    logic            manual_setting;
    capacity_s       capacity;
    logic [NCH-1:0]  sampled_channels;
    logic            sample_tick;
    logic            record_start;
    logic            record_stored;
    logic [15:0]     freq_protection;
    logic [15:0]     freq_display;
    logic            phase_order_flag;
    int              errors;
    int              checked;
    int              exp_n;

    // 1200 bytes per second and 3 ms records: 9 bytes give room for three
    disturbance_recorder_control #(.NUM_EXT(NE), .SAMPLE_DIV(SDIV), .MS_DIV(4), .MEM_BYTES(9))
    disturbance_recorder_control_i (
        .clock(clock), .nrst(nrst), .binary_in(binary_in),
        .trigger_select(trigger_select), .recorder_disable(recorder_disable),
        .recording_mode(recording_mode), .record_length_ms(21'h00_0003),
        .pretrigger_steps(pretrigger_steps), .analog_channels(5'h01),
        .analog_rate_sel(2'h3), .manual_trigger(manual_trigger), .clear_cmd(clear_cmd),
        .freq_measured(freq_measured), .freq_valid(freq_valid),
        .ntp_sync_lost(ntp_sync_lost), .internal_fault(internal_fault),
        .phase_reversed(phase_reversed), .recorder_state(recorder_state),
        .manual_setting(manual_setting), .capacity(capacity),
        .sampled_channels(sampled_channels), .sample_tick(sample_tick),
        .record_start(record_start), .record_stored(record_stored),
        .freq_protection(freq_protection), .freq_display(freq_display),
        .phase_order_flag(phase_order_flag));

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one manual recording; twice adds a second pulse mid-capture that must be dropped
    task automatic run_record(input logic twice);
        int i;
        int starts;
        int sets;
        logic seen_rec;
        starts = 0;
        sets = 0;
        seen_rec = 1'b0;
        manual_trigger = 1'b1;
        for (i = 0; i < 300 && record_stored !== 1'b1; i++) begin
            @(negedge clock);
            manual_trigger = twice && i == 4;
            if (manual_setting === 1'b1) sets++;
            if (record_start === 1'b1) starts++;
            if (recorder_state === 3'h2) seen_rec = 1'b1;
        end
        chk(i < 300, 1, "store timeout");
        chk(starts, 1, "record starts");
        chk(sets, twice ? 2 : 1, "manual readback pulses");
        chk(seen_rec, 1, "recording state seen");
        exp_n++;
        repeat (2) @(negedge clock);
        chk(capacity.stored, exp_n, "stored after store");
        chk(recorder_state, 0, "ready after store");
        $display("test record done");
    endtask

    // count starts over a span while triggers must be ignored
    task automatic refused(input string what);
        int starts;
        starts = 0;
        manual_trigger = 1'b1;
        repeat (12) begin
            @(negedge clock);
            manual_trigger = 1'b0;
            if (record_start === 1'b1) starts++;
        end
        chk(starts, 0, what);
    endtask

    task automatic t_static();
        {ntp_sync_lost, internal_fault, phase_reversed, freq_valid} = 4'h0e;
        repeat (2 * SDIV + 4) @(negedge clock);
        chk(sampled_channels[4:0], 5'h1e, "internal channels set");
        chk(freq_protection, 16'h1388, "protection freq fallback");
        chk(freq_display, 16'h0000, "display freq zero");
        chk(phase_order_flag, 1, "phase acb");
        {ntp_sync_lost, internal_fault, phase_reversed, freq_valid} = 4'h1;
        repeat (2 * SDIV + 4) @(negedge clock);
        chk(sampled_channels[4:0], 5'h02, "internal channels clear");
        chk(freq_protection, 16'h1380, "protection freq measured");
        chk(freq_display, 16'h1380, "display freq measured");
        chk(phase_order_flag, 0, "phase abc");
        $display("test static channels done");
    endtask

    task automatic t_tick();
        int n;
        n = 0;
        while (sample_tick !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (sample_tick !== 1'b1 && n < 50);
        chk(n, SDIV, "sample period");
        $display("test sample tick done");
    endtask

    // unselected channel must not trigger, selected one must
    task automatic t_auto();
        int n;
        int starts;
        starts = 0;
        trigger_select = NCH'(1) << CH_EXT;
        binary_in = 4'h2;
        repeat (3 * SDIV) begin
            @(negedge clock);
            if (record_start === 1'b1) starts++;
        end
        chk(starts, 0, "unselected channel started");
        binary_in = 4'h3;
        for (n = 0; n < 4 * SDIV && record_start !== 1'b1; n++) @(negedge clock);
        chk(record_start, 1, "selected channel start");
        for (n = 0; n < 300 && record_stored !== 1'b1; n++) @(negedge clock);
        chk(n < 300, 1, "auto store timeout");
        exp_n++;
        trigger_select = '0;
        binary_in = 4'h0;
        repeat (2) @(negedge clock);
        chk(capacity.stored, exp_n, "stored after auto");
        $display("test auto trigger done");
    endtask

    // full memory: keep mode refuses, fifo overwrites and holds the count
    task automatic t_full();
        int n;
        int starts;
        starts = 0;
        chk(recorder_state, 4, "full state");
        recording_mode = 1'b1;
        refused("start while full in keep mode");
        recording_mode = 1'b0;
        manual_trigger = 1'b1;
        for (n = 0; n < 300 && record_stored !== 1'b1; n++) begin
            @(negedge clock);
            manual_trigger = 1'b0;
            if (record_start === 1'b1) starts++;
        end
        chk(n < 300, 1, "fifo store timeout");
        chk(starts, 1, "fifo start when full");
        repeat (2) @(negedge clock);
        chk(capacity.stored, exp_n, "fifo overwrite keeps count");
        chk(recorder_state, 4, "still full after overwrite");
        $display("test full memory done");
    endtask

    task automatic clr(input logic [3:0] kind, input logic [31:0] idx, input int exp);
        clear_cmd = {kind, idx};
        @(negedge clock);
        clear_cmd = '0;
        repeat (2) @(negedge clock);
        chk(capacity.stored, exp, "stored after clear");
    endtask

    initial begin
        errors = 0;
        checked = 0;
        exp_n = 0;
        nrst = 1'b0;
        binary_in = '0;
        trigger_select = '0;
        recorder_disable = 1'b0;
        recording_mode = 1'b0;
        pretrigger_steps = 8'h00;
        manual_trigger = 1'b0;
        clear_cmd = '0;
        freq_measured = 16'h1380;
        freq_valid = 1'b1;
        {ntp_sync_lost, internal_fault, phase_reversed} = 3'h0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        chk(capacity.max_count <= 7'd100, 1, "max count limit");
        chk(capacity.max_count != 7'd0, 1, "room for records");
        chk(capacity.max_count, 3, "max count from sizing");
        chk(capacity.max_len_ms, 7, "max recording length");
        chk(capacity.max_pre_ms, 3, "max pre-trigger time");
        t_tick();
        t_static();
        run_record(1'b0);
        run_record(1'b1);
        // disabled recorder, then pre-trigger beyond length gives bad config
        recorder_disable = 1'b1;
        refused("start while disabled");
        recorder_disable = 1'b0;
        pretrigger_steps = 8'h01;
        repeat (3) @(negedge clock);
        chk(recorder_state, 5, "wrong config state");
        refused("start in wrong config");
        pretrigger_steps = 8'h00;
        repeat (3) @(negedge clock);
        t_auto();
        t_full();
        clr(4'h1, 32'h0000_0000, 3);
        clr(4'h1, 32'h0000_0004, 3);
        clr(4'h1, 32'h0000_0001, 2);
        clr(4'h4, 32'h0000_0000, 1);
        clr(4'h2, 32'h0000_0000, 0);
        exp_n = 0;
        run_record(1'b0);
        clr(4'h8, 32'h0000_0000, 0);
        clr(4'h4, 32'h0000_0000, 0);
        $display("test clears done");
        conclude();
    end

    // watchdog well beyond the expected few hundred cycles
    initial begin
        #160000;
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
